/* design/nand_host_pkg.sv */
package nand_host_pkg;

    // Timing figures in nanoseconds and the cycle counts derived from them.
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned T_STROBE_NS = 16;
    localparam int unsigned T_READ_LOW_NS = 32;
    localparam int unsigned T_BUSY_START_NS = 100;
    localparam int unsigned STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned READ_LOW_CYC = (T_READ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BUSY_START_CYC =
        (T_BUSY_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
    localparam logic [7:0] READ_LOW_CNT = 8'(READ_LOW_CYC);
    localparam logic [7:0] BUSY_START_CNT = 8'(BUSY_START_CYC);

    // Address layout.
    localparam int unsigned COL_W = 12;
    localparam int unsigned ROW_W = 19;
    localparam logic [2:0] ADDR_LAST_IDX = 3'h4;
    localparam logic [11:0] PAGE_BYTES = 12'h840;
    localparam int unsigned PLANE_BIT = 6;
    localparam int unsigned FIFO_DEPTH = 4;

    // Command codes.
    localparam logic [7:0] CMD_READ_1ST = 8'h00;
    localparam logic [7:0] CMD_RAND_OUT = 8'h05;
    localparam logic [7:0] CMD_PROG_CONF = 8'h10;
    localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
    localparam logic [7:0] CMD_READ_CONF = 8'h30;
    localparam logic [7:0] CMD_CACHE_SEQ = 8'h31;
    localparam logic [7:0] CMD_COPY_READ = 8'h35;
    localparam logic [7:0] CMD_CACHE_END = 8'h3F;
    localparam logic [7:0] CMD_ERASE_1ST = 8'h60;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
    localparam logic [7:0] CMD_PROG_1ST = 8'h80;
    localparam logic [7:0] CMD_RAND_IN = 8'h85;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_ERASE_CONF = 8'hD0;
    localparam logic [7:0] CMD_RAND_OUT_CONF = 8'hE0;
    localparam logic [7:0] CMD_PARAM_PAGE = 8'hEC;
    localparam logic [7:0] CMD_UNIQUE_ID = 8'hED;
    localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
    localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
    localparam logic [7:0] CMD_RESET = 8'hFF;

    typedef enum logic [2:0] {
        OP_CMD = 3'h0,
        OP_ADDR = 3'h1,
        OP_WRITE = 3'h2,
        OP_READ = 3'h3,
        OP_WAIT = 3'h4
    } op_kind_type;

    typedef struct packed {
        op_kind_type kind;
        logic [7:0] data;
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
    } host_req_type;

    typedef struct packed {
        logic chip_sel_n;
        logic cmd_latch;
        logic addr_latch;
        logic write_strobe_low;
        logic read_strobe_low;
        logic write_guard_n;
        logic [7:0] io_out;
        logic io_oe;
    } pins_out_type;

    localparam pins_out_type PINS_IDLE = '{
        chip_sel_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0, write_strobe_low: 1'b1,
        read_strobe_low: 1'b1, write_guard_n: 1'b0, io_out: 8'h00, io_oe: 1'b0};

    function automatic logic is_defined_cmd(input logic [7:0] code);
        case (code)
            CMD_READ_1ST, CMD_RAND_OUT, CMD_PROG_CONF, CMD_CACHE_PROG, CMD_READ_CONF,
            CMD_CACHE_SEQ, CMD_COPY_READ, CMD_CACHE_END, CMD_ERASE_1ST, CMD_STATUS,
            CMD_STATUS_ENH, CMD_PROG_1ST, CMD_RAND_IN, CMD_READ_ID, CMD_ERASE_CONF,
            CMD_RAND_OUT_CONF, CMD_PARAM_PAGE, CMD_UNIQUE_ID, CMD_GET_FEAT, CMD_SET_FEAT,
            CMD_RESET: is_defined_cmd = 1'b1;
            default: is_defined_cmd = 1'b0;
        endcase
    endfunction : is_defined_cmd

    function automatic logic busy_ok_cmd(input logic [7:0] code);
        busy_ok_cmd = (code == CMD_STATUS) || (code == CMD_RESET);
    endfunction : busy_ok_cmd

endpackage : nand_host_pkg

/* design/read_fifo.sv */
`timescale 1ns/1ns
module read_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // Filling side.
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side.
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [PW:0] count_q, count_d;
    logic push, pop;

    assign in_ready = (count_q != (PW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d = count_q;
        if (push) begin
            wr_ptr_d = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_q + 1'b1);
        end
        if (pop) begin
            rd_ptr_d = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_q + 1'b1);
        end
        if (push && !pop) begin
            count_d = (PW+1)'(count_q + 1'b1);
        end else if (pop && !push) begin
            count_d = (PW+1)'(count_q - 1'b1);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
        end
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                mem_q[i] <= '0;
            end else if (push && (wr_ptr_q == PW'(i))) begin
                mem_q[i] <= in_data;
            end
        end
    end
endmodule : read_fifo

/* design/nand_host_ctrl.sv */
`timescale 1ns/1ns
module nand_host_ctrl
    import nand_host_pkg::*;
#(
    parameter int unsigned DATA_W = 8,
    parameter int unsigned RD_DEPTH = FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // Request port.
    input wire logic req_valid,
    input wire host_req_type req,
    output logic req_ready,
    output logic req_error,
    input wire logic write_protect,
    output logic device_ready,
    // Read data stream.
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data,
    input wire logic rd_ready,
    // Flash pins.
    output pins_out_type pins,
    input wire logic [7:0] io_in,
    input wire logic ready_busy_line
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOW = 4'h2,
        ST_HIGH = 4'h4,
        ST_WAIT = 4'h8
    } state_type;

    state_type state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    op_kind_type kind_q, kind_d;
    logic [COL_W-1:0] col_q, col_d;
    logic [ROW_W-1:0] row_q, row_d;
    logic [2:0] idx_q, idx_d;
    pins_out_type pins_q, pins_d;
    logic err_q, err_d;
    logic push_q, push_d;
    logic [7:0] push_data_q, push_data_d;
    logic rb_meta_q, rb_sync_q;
    logic [7:0] io_meta_q, io_sync_q;
    logic fifo_in_ready;
    logic refuse;

    // Address bytes with the unused upper bits forced low.
    function automatic logic [7:0] addr_byte(input logic [COL_W-1:0] col,
                                             input logic [ROW_W-1:0] row,
                                             input logic [2:0] idx);
        case (idx)
            3'h0: addr_byte = col[7:0];
            3'h1: addr_byte = {4'h0, col[11:8]};
            3'h2: addr_byte = row[7:0];
            3'h3: addr_byte = row[15:8];
            default: addr_byte = {5'h00, row[18:16]};
        endcase
    endfunction : addr_byte

    // Strobe-low drive for one bus cycle; reads keep the write strobe high.
    function automatic pins_out_type drive(input op_kind_type kind, input logic [7:0] data,
                                           input logic guard_n);
        drive = PINS_IDLE;
        drive.chip_sel_n = 1'b0;
        drive.write_guard_n = guard_n;
        drive.cmd_latch = (kind == OP_CMD);
        drive.addr_latch = (kind == OP_ADDR);
        if (kind == OP_READ) begin
            drive.read_strobe_low = 1'b0;
        end else begin
            drive.write_strobe_low = 1'b0;
            drive.io_out = data;
            drive.io_oe = 1'b1;
        end
    endfunction : drive

    // Pins and the busy line are asynchronous to sys_clk.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rb_meta_q <= 1'b0;
            rb_sync_q <= 1'b0;
            io_meta_q <= 8'h00;
            io_sync_q <= 8'h00;
        end else begin
            rb_meta_q <= ready_busy_line;
            rb_sync_q <= rb_meta_q;
            io_meta_q <= io_in;
            io_sync_q <= io_meta_q;
        end
    end

    always_comb begin
        refuse = 1'b0;
        if (req.kind == OP_CMD) begin
            refuse = !is_defined_cmd(req.data)
                || (!rb_sync_q && !busy_ok_cmd(req.data));
        end else if (req.kind != OP_WAIT) begin
            refuse = !rb_sync_q;
        end
        if ((req.kind == OP_ADDR) && (req.col >= PAGE_BYTES)) begin
            refuse = 1'b1;
        end
    end

    // A read is held off while the buffer is full, so the stream never drops a byte.
    assign req_ready = (state_q == ST_IDLE) && !((req.kind == OP_READ) && !fifo_in_ready);

    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q == 8'h00) ? 8'h00 : 8'(cnt_q - 8'h01);
        kind_d = kind_q;
        col_d = col_q;
        row_d = row_q;
        idx_d = idx_q;
        pins_d = pins_q;
        pins_d.write_guard_n = !write_protect;
        err_d = 1'b0;
        push_d = 1'b0;
        push_data_d = push_data_q;
        case (state_q)
            ST_IDLE: begin
                if (req_valid && req_ready) begin
                    if (refuse) begin
                        err_d = 1'b1;
                    end else if (req.kind == OP_WAIT) begin
                        state_d = ST_WAIT;
                        cnt_d = 8'(BUSY_START_CNT - 8'h01);
                    end else begin
                        kind_d = req.kind;
                        col_d = req.col;
                        row_d = req.row;
                        idx_d = 3'h0;
                        pins_d = drive(req.kind, (req.kind == OP_ADDR) ?
                            addr_byte(req.col, req.row, 3'h0) : req.data, !write_protect);
                        state_d = ST_LOW;
                        cnt_d = (req.kind == OP_READ) ? 8'(READ_LOW_CNT - 8'h01) :
                            8'(STROBE_CNT - 8'h01);
                    end
                end
            end
            ST_LOW: begin
                if (cnt_q == 8'h00) begin
                    if (kind_q == OP_READ) begin
                        push_d = 1'b1;
                        push_data_d = io_sync_q;
                    end
                    // Latch selects and data stay put across the rising edge for hold time.
                    pins_d.write_strobe_low = 1'b1;
                    pins_d.read_strobe_low = 1'b1;
                    state_d = ST_HIGH;
                    cnt_d = 8'(STROBE_CNT - 8'h01);
                end
            end
            ST_HIGH: begin
                if (cnt_q == 8'h00) begin
                    if ((kind_q == OP_ADDR) && (idx_q != ADDR_LAST_IDX)) begin
                        idx_d = 3'(idx_q + 3'h1);
                        pins_d = drive(OP_ADDR, addr_byte(col_q, row_q, 3'(idx_q + 3'h1)),
                            !write_protect);
                        state_d = ST_LOW;
                        cnt_d = 8'(STROBE_CNT - 8'h01);
                    end else begin
                        pins_d = PINS_IDLE;
                        pins_d.write_guard_n = !write_protect;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                // The device takes a while to pull the line low; ignore it until then.
                if ((cnt_q == 8'h00) && rb_sync_q) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            kind_q <= OP_CMD;
            col_q <= '0;
            row_q <= '0;
            idx_q <= 3'h0;
            pins_q <= PINS_IDLE;
            err_q <= 1'b0;
            push_q <= 1'b0;
            push_data_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            kind_q <= kind_d;
            col_q <= col_d;
            row_q <= row_d;
            idx_q <= idx_d;
            pins_q <= pins_d;
            err_q <= err_d;
            push_q <= push_d;
            push_data_q <= push_data_d;
        end
    end

    assign pins = pins_q;
    assign req_error = err_q;
    assign device_ready = rb_sync_q;

    read_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(RD_DEPTH)
    ) u_read_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(push_q),
        .in_data(DATA_W'(push_data_q)),
        .in_ready(fifo_in_ready),
        .out_valid(rd_valid),
        .out_data(rd_data),
        .out_ready(rd_ready)
    );

    property p_col_low;
        @(posedge sys_clk) disable iff (!rstn)
        (state_q == ST_LOW) && pins_q.addr_latch && (idx_q == 3'h0)
            |-> (pins_q.io_out == col_q[7:0]) && (pins_q.io_oe);
    endproperty
    a_col_low: assert property (p_col_low) else $error("first address byte wrong");

    property p_row_first;
        @(posedge sys_clk) disable iff (!rstn)
        (state_q == ST_LOW) && pins_q.addr_latch && (idx_q == 3'h2)
            |-> pins_q.io_out == row_q[7:0];
    endproperty
    a_row_first: assert property (p_row_first) else $error("third address byte wrong");

    property p_pad_low;
        @(posedge sys_clk) disable iff (!rstn)
        pins_q.addr_latch && ((idx_q == 3'h1) || (idx_q == 3'h4))
            |-> (pins_q.io_out[7:4] == 4'h0) && ((idx_q == 3'h1) || !pins_q.io_out[3]);
    endproperty
    a_pad_low: assert property (p_pad_low) else $error("unused address bits high");

    property p_busy_cmd;
        @(posedge sys_clk) disable iff (!rstn)
        (state_q == ST_IDLE) && req_valid && (req.kind == OP_CMD) && !rb_sync_q
            && !busy_ok_cmd(req.data) |=> err_q && (state_q == ST_IDLE);
    endproperty
    a_busy_cmd: assert property (p_busy_cmd) else $error("command sent while busy");

    property p_read_pins;
        @(posedge sys_clk) disable iff (!rstn)
        !pins_q.read_strobe_low |-> !pins_q.addr_latch && !pins_q.cmd_latch
            && !pins_q.chip_sel_n && pins_q.write_strobe_low && !pins_q.io_oe;
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("read strobe pin levels");

    property p_read_width;
        @(posedge sys_clk) disable iff (!rstn)
        $fell(pins_q.read_strobe_low) |-> !pins_q.read_strobe_low [*4] ##1 pins_q.read_strobe_low;
    endproperty
    a_read_width: assert property (p_read_width) else $error("read strobe width");

    property p_defined_cmd;
        @(posedge sys_clk) disable iff (!rstn)
        $fell(pins_q.write_strobe_low) && pins_q.cmd_latch |-> is_defined_cmd(pins_q.io_out);
    endproperty
    a_defined_cmd: assert property (p_defined_cmd) else $error("undefined command sent");

    property p_in_page;
        @(posedge sys_clk) disable iff (!rstn)
        (state_q == ST_IDLE) && req_valid && (req.kind == OP_ADDR) && (req.col >= PAGE_BYTES)
            |=> err_q ##1 (state_q == ST_IDLE) && pins_q.chip_sel_n;
    endproperty
    a_in_page: assert property (p_in_page) else $error("column outside page");
endmodule : nand_host_ctrl

/* verification/nand_dev_model.sv */
`timescale 1ns/1ns
module nand_dev_model
    import nand_host_pkg::*;
#(
    parameter int unsigned BUSY_CYC = 40
) (
    // Clock used only to time the busy period.
    input wire logic sys_clk,
    // Pins driven by the host.
    input wire pins_out_type pins,
    // Pins driven by the device.
    output logic [7:0] dev_io,
    output logic dev_io_en,
    output logic ready_busy_line,
    // Observed state.
    output logic [7:0] last_cmd,
    output logic [COL_W-1:0] cap_col,
    output logic [ROW_W-1:0] cap_row,
    output logic plane,
    output logic [7:0] last_data,
    output int op_count,
    output int addr_bad
);
    logic [7:0] abyte [5];
    logic [COL_W-1:0] rd_col;
    logic status_mode;
    int acnt;
    int busy_cnt;
    int seen_ops;
    wire sel = !pins.chip_sel_n;

    initial begin
        dev_io = 8'h00;
        last_cmd = 8'h00;
        last_data = 8'h00;
        rd_col = '0;
        status_mode = 1'b0;
        acnt = 0;
        busy_cnt = 0;
        seen_ops = 0;
        op_count = 0;
        addr_bad = 0;
        ready_busy_line = 1'b1;
        foreach (abyte[i]) abyte[i] = 8'h00;
    end

    assign cap_col = {abyte[1][3:0], abyte[0]};
    assign cap_row = {abyte[4][2:0], abyte[3], abyte[2]};
    assign plane = cap_row[6];
    // Once released the bench shows the inverted last byte, so a stale sample cannot match.
    assign dev_io_en = sel && !pins.read_strobe_low;

    always @(posedge pins.write_strobe_low) begin
        if (sel && pins.cmd_latch) begin
            last_cmd = pins.io_out;
            status_mode = (pins.io_out == CMD_STATUS);
            acnt = 0;
            case (pins.io_out)
                CMD_READ_CONF, CMD_COPY_READ: begin
                    rd_col = cap_col;
                    op_count++;
                end
                CMD_CACHE_SEQ, CMD_CACHE_END: begin
                    rd_col = '0;
                    op_count++;
                end
                CMD_RAND_OUT_CONF: rd_col = cap_col;
                CMD_PROG_CONF, CMD_CACHE_PROG, CMD_ERASE_CONF: begin
                    if (pins.write_guard_n) op_count++;
                end
                CMD_RESET: op_count++;
                default: ;
            endcase
        end else if (sel && pins.addr_latch) begin
            if (acnt < 5) begin
                if (acnt == 1 && pins.io_out[7:4] != 4'h0) addr_bad++;
                if (acnt == 4 && pins.io_out[7:3] != 5'h00) addr_bad++;
                abyte[acnt] = pins.io_out;
            end
            acnt++;
        end else if (sel) begin
            last_data = pins.io_out;
        end
    end

    // Every started operation holds the line low for a fixed span.
    always @(posedge sys_clk) begin
        if (op_count != seen_ops) begin
            seen_ops = op_count;
            busy_cnt = BUSY_CYC;
        end else if (busy_cnt > 0) begin
            busy_cnt--;
        end
        ready_busy_line <= (busy_cnt == 0);
    end

    // The select pin falls in the same step as the strobe, so read it directly, not via sel.
    always @(negedge pins.read_strobe_low) begin
        if (!pins.chip_sel_n && !pins.addr_latch && pins.write_strobe_low) begin
            if (status_mode) begin
                dev_io = {pins.write_guard_n, ready_busy_line, 6'h00};
            end else begin
                dev_io = rd_col[7:0] ^ cap_row[7:0] ^ 8'h5A;
                rd_col++;
            end
        end
    end
endmodule : nand_dev_model

/* verification/tb.sv */
`timescale 1ns/1ns
module tb;
    import nand_host_pkg::*;

    logic sys_clk;
    logic rstn;
    logic req_valid;
    host_req_type req;
    logic req_ready;
    logic req_error;
    logic write_protect;
    logic device_ready;
    logic rd_valid;
    logic [7:0] rd_data;
    logic rd_ready;
    pins_out_type pins;
    logic [7:0] io_in;
    logic ready_busy_line;
    logic [7:0] dev_io;
    logic dev_io_en;
    logic [7:0] last_cmd;
    logic [COL_W-1:0] cap_col;
    logic [ROW_W-1:0] cap_row;
    logic plane;
    logic [7:0] last_data;
    int op_count;
    int addr_bad;
    int num_errors = 0;
    int checked = 0;
    int ops;
    logic err;
    logic [11:0] col;
    logic [18:0] row;
    logic [7:0] d;
    logic [7:0] codes [12] = '{8'h31, 8'h3F, 8'h35, 8'h85, 8'h10, 8'h15, 8'h60, 8'hD0,
        8'h05, 8'hE0, 8'hFF, 8'h70};

    // Whoever enables wins the shared byte; a floating bus shows a stale inverted value.
    assign io_in = pins.io_oe ? pins.io_out : (dev_io_en ? dev_io : ~dev_io);

    nand_host_ctrl #(.DATA_W(8), .RD_DEPTH(4)) dut (.sys_clk(sys_clk), .rstn(rstn),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .req_error(req_error),
        .write_protect(write_protect), .device_ready(device_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_ready(rd_ready), .pins(pins), .io_in(io_in),
        .ready_busy_line(ready_busy_line));

    nand_dev_model flash (.sys_clk(sys_clk), .pins(pins), .dev_io(dev_io),
        .dev_io_en(dev_io_en), .ready_busy_line(ready_busy_line), .last_cmd(last_cmd),
        .cap_col(cap_col), .cap_row(cap_row), .plane(plane), .last_data(last_data),
        .op_count(op_count), .addr_bad(addr_bad));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] exp_byte(input logic [11:0] c, input logic [18:0] r);
        return c[7:0] ^ r[7:0] ^ 8'h5A;
    endfunction : exp_byte

    function automatic logic is_op(input logic [7:0] c);
        return c inside {8'h30, 8'h31, 8'h3F, 8'h35, 8'h10, 8'h15, 8'hD0, 8'hFF};
    endfunction : is_op

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // Holds the request from a falling edge until the edge that takes it.
    task automatic send(input op_kind_type kind, input logic [7:0] data,
            input logic [11:0] c, input logic [18:0] r, output logic e);
        @(negedge sys_clk);
        req_valid = 1'b1;
        req = '{kind: kind, data: data, col: c, row: r};
        // Let req_ready settle on the new request before looking at it.
        #1;
        while (req_ready !== 1'b1) begin
            @(negedge sys_clk);
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        e = req_error;
    endtask : send

    task automatic idle();
        while (req_ready !== 1'b1) begin
            @(negedge sys_clk);
        end
    endtask : idle

    task automatic do_cmd(input logic [7:0] code, input logic exp_err);
        logic e;
        send(OP_CMD, code, '0, '0, e);
        check(e, exp_err, "command refusal");
        idle();
    endtask : do_cmd

    task automatic do_addr(input logic [11:0] c, input logic [18:0] r, input logic exp_err);
        logic e;
        send(OP_ADDR, 8'h00, c, r, e);
        check(e, exp_err, "address refusal");
        idle();
    endtask : do_addr

    // Pops with random stalls and compares against the page pattern.
    task automatic drain(input logic [11:0] c, input logic [18:0] r, input int cnt);
        while (cnt > 0) begin
            @(negedge sys_clk);
            rd_ready = 1'($urandom % 2);
            if (rd_valid === 1'b1 && rd_ready) begin
                check(rd_data, exp_byte(c, r), "read byte");
                c++;
                cnt--;
            end
        end
        @(negedge sys_clk);
        rd_ready = 1'b0;
    endtask : drain

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        rd_ready = 1'b0;
        write_protect = 1'b0;
        void'($urandom(80));
        repeat (5) @(negedge sys_clk);
        check(pins.chip_sel_n, 1'b1, "select in reset");
        check(pins.io_oe, 1'b0, "bus driven in reset");
        rstn = 1'b1;
        send(OP_WAIT, 8'h00, '0, '0, err);
        col = 12'($urandom % 2040);
        row = 19'($urandom);
        do_cmd(CMD_READ_1ST, 1'b0);
        do_addr(col, row, 1'b0);
        check(cap_col, col, "column");
        check(cap_row, row, "row");
        check(plane, row[6], "plane");
        do_cmd(CMD_READ_CONF, 1'b0);
        for (int n = 0; n < 60 && device_ready !== 1'b0; n++) @(negedge sys_clk);
        check(device_ready, 1'b0, "busy after read");
        do_cmd(CMD_READ_1ST, 1'b1);
        do_cmd(CMD_STATUS, 1'b0);
        send(OP_WAIT, 8'h00, '0, '0, err);
        do_cmd(CMD_READ_1ST, 1'b0);
        repeat (FIFO_DEPTH) send(OP_READ, 8'h00, '0, '0, err);
        repeat (10) @(negedge sys_clk);
        req.kind = OP_READ;
        check(req_ready, 1'b0, "full buffer");
        drain(col, row, FIFO_DEPTH);
        repeat (2) send(OP_READ, 8'h00, '0, '0, err);
        drain(col + 12'd4, row, 2);
        d = last_cmd;
        do_cmd(8'h01, 1'b1);
        do_addr(PAGE_BYTES, row, 1'b1);
        check(last_cmd, d, "refused command on pins");
        for (int wp = 1; wp >= 0; wp--) begin
            write_protect = wp[0];
            ops = op_count;
            d = 8'($urandom);
            do_cmd(CMD_PROG_1ST, 1'b0);
            do_addr(12'h83F, 19'h7FFFF, 1'b0);
            check(addr_bad, 0, "upper address bits");
            do_addr(12'h000, 19'h00000, 1'b0);
            check(cap_col, 12'h83F, "last column");
            send(OP_WRITE, d, '0, '0, err);
            idle();
            check(last_data, d, "data byte");
            do_cmd(CMD_PROG_CONF, 1'b0);
            send(OP_WAIT, 8'h00, '0, '0, err);
            idle();
            check(op_count - ops, 1 - wp, "guarded program");
        end
        foreach (codes[i]) begin
            ops = op_count;
            do_cmd(codes[i], 1'b0);
            check(last_cmd, codes[i], "command latch");
            send(OP_WAIT, 8'h00, '0, '0, err);
            idle();
            check(op_count - ops, is_op(codes[i]), "operation start");
        end
        stop_test();
    end
endmodule : tb
